// ==== inc/crs_regs.svh ====
// Constants for the reset and interrupt sequencer.
// Assumes inclusion by bare name from rtl files.
`ifndef CRS_REGS_SVH
`define CRS_REGS_SVH
`define CRS_RST_VEC_LO   16'hFFFC
`define CRS_RST_VEC_HI   16'hFFFD
`define CRS_IRQ_VEC_LO   16'hFFFE
`define CRS_IRQ_VEC_HI   16'hFFFF
`define CRS_STACK_PAGE   8'h01
`define CRS_SP_RESET     8'hFF
`define CRS_INIT_CYCLES  4'h6
`define CRS_PWR_HOLD     2'h2
`define CRS_MASK_BIT     3'h2
`define CRS_STATUS_RESET 8'h20
`endif

// ==== inc/crs_pkg.sv ====
// Types for the reset and interrupt sequencer.
// Assumes no other package.
package crs_pkg;
    typedef enum logic [9:0] {
        CRS_ST_HOLD  = 10'h001,
        CRS_ST_INIT  = 10'h002,
        CRS_ST_RVLO  = 10'h004,
        CRS_ST_RVHI  = 10'h008,
        CRS_ST_RUN   = 10'h010,
        CRS_ST_PSHH  = 10'h020,
        CRS_ST_PSHL  = 10'h040,
        CRS_ST_PSHP  = 10'h080,
        CRS_ST_IVLO  = 10'h100,
        CRS_ST_IVHI  = 10'h200
    } crs_state_e;
endpackage

// ==== rtl/crs_sync.sv ====
// Three-stage input synchroniser with agreement of the last two stages.
// Assumes clk is the core clock.
`timescale 1ns/1ps
`default_nettype none
module crs_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,    // Core clock
    input  wire logic nrst,   // Async reset, active low
    input  wire logic ce,     // Clock enable
    input  wire logic din,    // Asynchronous input
    output logic      dout    // Filtered level
);
    logic [2:0] sh_q;
    logic       out_q;
    // Shift and accept once stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sh_q  <= {3{RST_VAL}};
            out_q <= RST_VAL;
        end else if (ce) begin
            sh_q <= {sh_q[1:0], din};
            if (sh_q[1] == sh_q[2]) begin
                out_q <= sh_q[2];
            end
        end
    end
    assign dout = out_q;
endmodule
`default_nettype wire

// ==== rtl/crs_sequencer.sv ====
// Reset and maskable interrupt entry sequencer of an 8-bit processor core.
// Assumes a memory answering reads in the cycle the address stands and
// an execution core that flags instruction boundaries.
`timescale 1ns/1ps
`default_nettype none
`include "crs_regs.svh"
module crs_sequencer (
    input  wire logic        clk,                  // Core clock, 25 MHz
    input  wire logic        nrst,                 // Async reset, active low
    input  wire logic        ce,                   // Clock enable
    input  wire logic        processor_reset_n,    // Reset pin, active low
    input  wire logic        irq_n,                // Interrupt pin, active low
    input  wire logic        insn_done,            // Instruction boundary
    input  wire logic        mask_clr,             // Core clears mask
    input  wire logic        mask_set,             // Core sets mask
    input  wire logic [15:0] pc_in,                // Core program counter
    input  wire logic [7:0]  data_bus_lines_in,    // Data pins in
    output logic [7:0]       data_bus_lines_out,   // Data pins out
    output logic             data_bus_lines_oe,    // Data pins drive
    output logic [15:0]      address_bus_lines,    // Address pins
    output logic             rw,                   // High read, low write
    output logic             rw_valid,             // Direction is valid
    output logic             core_run,             // Core may execute
    output logic [15:0]      pc_out,               // Loaded program counter
    output logic             pc_load,              // PC load pulse
    output logic [7:0]       status_out,           // Status register
    output logic [7:0]       sp_out                // Stack pointer
);
    crs_pkg::crs_state_e st_q, st_d;
    logic        rst_s, irq_s, rst_prev_q;
    logic [3:0]  cnt_q, cnt_d;
    logic [1:0]  hold_q;
    logic [7:0]  lo_q, sp_q, stat_q, dout_q;
    logic [15:0] pc_q, addr_q, saved_q;
    logic        rw_q, oe_q, rwv_q, run_q, pcl_q;

    // Pin synchronisers
    crs_sync #(.RST_VAL(1'b0)) u_rst (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  (processor_reset_n),
        .dout (rst_s)
    );
    crs_sync #(.RST_VAL(1'b1)) u_irq (
        .clk  (clk),
        .nrst (nrst),
        .ce   (ce),
        .din  (irq_n),
        .dout (irq_s)
    );

    wire rst_rise = rst_s && !rst_prev_q;
    wire mask_on  = stat_q[`CRS_MASK_BIT];
    wire irq_take = (st_q == crs_pkg::CRS_ST_RUN) && insn_done
                    && !irq_s && !mask_on;
    // Writes launch from the next state, so they stand in the state cycle
    wire pushing  = (st_d == crs_pkg::CRS_ST_PSHH)
                    || (st_d == crs_pkg::CRS_ST_PSHL)
                    || (st_d == crs_pkg::CRS_ST_PSHP);
    wire wr_ok    = pushing && rst_s;
    wire [15:0] stack_addr = {`CRS_STACK_PAGE, sp_q};
    wire [15:0] vec_pc     = {data_bus_lines_in, lo_q};

    // Next state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (!rst_s) begin
            st_d = crs_pkg::CRS_ST_HOLD;
        end else if (rst_rise) begin
            st_d  = crs_pkg::CRS_ST_INIT;
            cnt_d = 4'h1;
        end else begin
            unique case (st_q)
                crs_pkg::CRS_ST_HOLD: st_d = crs_pkg::CRS_ST_HOLD;
                crs_pkg::CRS_ST_INIT: begin
                    if (cnt_q == `CRS_INIT_CYCLES) begin
                        st_d = crs_pkg::CRS_ST_RVLO;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
                crs_pkg::CRS_ST_RVLO: st_d = crs_pkg::CRS_ST_RVHI;
                crs_pkg::CRS_ST_RVHI: st_d = crs_pkg::CRS_ST_RUN;
                crs_pkg::CRS_ST_RUN:
                    if (irq_take) st_d = crs_pkg::CRS_ST_PSHH;
                crs_pkg::CRS_ST_PSHH: st_d = crs_pkg::CRS_ST_PSHL;
                crs_pkg::CRS_ST_PSHL: st_d = crs_pkg::CRS_ST_PSHP;
                crs_pkg::CRS_ST_PSHP: st_d = crs_pkg::CRS_ST_IVLO;
                crs_pkg::CRS_ST_IVLO: st_d = crs_pkg::CRS_ST_IVHI;
                crs_pkg::CRS_ST_IVHI: st_d = crs_pkg::CRS_ST_RUN;
                default:              st_d = crs_pkg::CRS_ST_HOLD;
            endcase
        end
    end

    // State, counters, edge history
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q       <= crs_pkg::CRS_ST_HOLD;
            cnt_q      <= 4'h0;
            rst_prev_q <= 1'b0;
            hold_q     <= 2'h0;
        end else if (ce) begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            rst_prev_q <= rst_s;
            if (rst_s) begin
                hold_q <= 2'h0;
            end else if (hold_q != `CRS_PWR_HOLD) begin
                hold_q <= hold_q + 2'h1;
            end
        end
    end

    // Valid direction once held low two cycles, stays valid after
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rwv_q <= 1'b0;
        end else if (ce && hold_q == `CRS_PWR_HOLD) begin
            rwv_q <= 1'b1;
        end
    end

    // Bus address, direction and write data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_q <= 16'h0000;
            rw_q   <= 1'b1;
            oe_q   <= 1'b0;
            dout_q <= 8'h00;
        end else if (ce) begin
            rw_q <= !wr_ok;
            oe_q <= wr_ok;
            unique case (st_d)
                crs_pkg::CRS_ST_RVLO:
                    addr_q <= `CRS_RST_VEC_LO;
                crs_pkg::CRS_ST_RVHI:
                    addr_q <= `CRS_RST_VEC_HI;
                crs_pkg::CRS_ST_PSHH: begin
                    addr_q <= stack_addr;
                    dout_q <= pc_in[15:8];
                end
                crs_pkg::CRS_ST_PSHL: begin
                    addr_q <= stack_addr;
                    dout_q <= saved_q[7:0];
                end
                crs_pkg::CRS_ST_PSHP: begin
                    addr_q <= stack_addr;
                    dout_q <= stat_q;
                end
                crs_pkg::CRS_ST_IVLO:
                    addr_q <= `CRS_IRQ_VEC_LO;
                crs_pkg::CRS_ST_IVHI:
                    addr_q <= `CRS_IRQ_VEC_HI;
                default:
                    addr_q <= pc_in;
            endcase
        end
    end

    // Vector capture, stack pointer, status and PC
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lo_q    <= 8'h00;
            sp_q    <= `CRS_SP_RESET;
            stat_q  <= `CRS_STATUS_RESET;
            pc_q    <= 16'h0000;
            saved_q <= 16'h0000;
            pcl_q   <= 1'b0;
            run_q   <= 1'b0;
        end else if (ce) begin
            pcl_q <= 1'b0;
            if (irq_take) saved_q <= pc_in;
            if (mask_set) stat_q[`CRS_MASK_BIT] <= 1'b1;
            else if (mask_clr) stat_q[`CRS_MASK_BIT] <= 1'b0;
            if (wr_ok) sp_q <= sp_q - 8'h01;
            unique case (st_q)
                crs_pkg::CRS_ST_RVLO, crs_pkg::CRS_ST_IVLO:
                    lo_q <= data_bus_lines_in;
                default: ;
            endcase
            run_q <= (st_d == crs_pkg::CRS_ST_RUN);
            if (st_q == crs_pkg::CRS_ST_RVHI && rst_s && !rst_rise) begin
                stat_q[`CRS_MASK_BIT] <= 1'b1;
                pc_q  <= vec_pc;
                pcl_q <= 1'b1;
            end
            if (st_q == crs_pkg::CRS_ST_PSHP) begin
                stat_q[`CRS_MASK_BIT] <= 1'b1;
            end
            if (st_q == crs_pkg::CRS_ST_IVHI && rst_s && !rst_rise) begin
                pc_q  <= vec_pc;
                pcl_q <= 1'b1;
            end
        end
    end

    assign data_bus_lines_out = dout_q;
    assign data_bus_lines_oe  = oe_q;
    assign address_bus_lines  = addr_q;
    assign rw                 = rw_q;
    assign rw_valid           = rwv_q;
    assign core_run           = run_q;
    assign pc_out             = pc_q;
    assign pc_load            = pcl_q;
    assign status_out         = stat_q;
    assign sp_out             = sp_q;
endmodule
`default_nettype wire

// ==== dv/crs_mem_model.sv ====
// Memory model on the far side of the sequencer's bus.
// Assumes reads are answered in the cycle the registered address stands.
`timescale 1ns/1ps
`default_nettype none
module crs_mem_model #(
    parameter logic [15:0] RVEC = 16'h1234, // Reset vector contents
    parameter logic [15:0] IVEC = 16'h5678  // Interrupt vector contents
) (
    input  wire logic [15:0] addr,  // Address from device
    input  wire logic        oe,    // Device drives data
    output logic      [7:0]  rdata  // Read data to device
);
    // Vector bytes, no answer while driven, else an address pattern
    always_comb begin
        case (addr)
            16'hFFFC: rdata = RVEC[7:0];
            16'hFFFD: rdata = RVEC[15:8];
            16'hFFFE: rdata = IVEC[7:0];
            16'hFFFF: rdata = IVEC[15:8];
            default:  rdata = oe ? 8'h00 : ~addr[7:0];
        endcase
    end
endmodule
`default_nettype wire

// ==== dv/crs_sequencer_properties.sv ====
// Port checker for the sequencer.
// Assumes binding onto crs_sequencer.
`timescale 1ns/1ps
`default_nettype none
module crs_seq_chk (
    input wire logic        clk,                // Core clock
    input wire logic        nrst,               // Async reset
    input wire logic        processor_reset_n,  // Reset pin
    input wire logic [15:0] pc_in,              // Core PC
    input wire logic [7:0]  data_bus_lines_out, // Write data
    input wire logic        data_bus_lines_oe,  // Data drive
    input wire logic [15:0] address_bus_lines,  // Address
    input wire logic        rw,                 // Direction
    input wire logic        rw_valid,           // Direction valid
    input wire logic [7:0]  status_out          // Status
);
    logic [2:0] low_q; // Pin-low run length
    // Count pin-low cycles, saturating
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            low_q <= 3'h0;
        else if (processor_reset_n)
            low_q <= 3'h0;
        else if (low_q != 3'h7)
            low_q <= low_q + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_no_wr;
        low_q >= 3'h5 |-> rw && !data_bus_lines_oe;
    endproperty
    a_no_wr: assert property (p_no_wr) else $error("write in reset");
    property p_rw_valid;
        low_q == 3'h7 |-> rw_valid;
    endproperty
    a_rw_valid: assert property (p_rw_valid) else $error("rw invalid");
    property p_oe_dir;
        data_bus_lines_oe == !rw;
    endproperty
    a_oe_dir: assert property (p_oe_dir) else $error("drive");
    property p_push;
        $fell(rw) |-> address_bus_lines[15:8] == 8'h01
            && data_bus_lines_out == pc_in[15:8]
            ##1 data_bus_lines_out == pc_in[7:0]
            ##1 !data_bus_lines_out[2] ##1 rw;
    endproperty
    a_push: assert property (p_push) else $error("push");
    property p_masked;
        $fell(rw) |-> !$past(status_out[2]);
    endproperty
    a_masked: assert property (p_masked) else $error("masked");
    property p_mask_after;
        $fell(rw) |-> ##[3:4] status_out[2];
    endproperty
    a_mask_after: assert property (p_mask_after) else $error("mask");
    property p_ivec;
        $fell(rw) |-> ##[3:4] address_bus_lines == 16'hFFFE
            ##1 address_bus_lines == 16'hFFFF;
    endproperty
    a_ivec: assert property (p_ivec) else $error("irq vector");
    property p_rvec;
        address_bus_lines == 16'hFFFC |=> address_bus_lines == 16'hFFFD;
    endproperty
    a_rvec: assert property (p_rvec) else $error("rst vector");
endmodule
bind crs_sequencer crs_seq_chk u_chk (.clk, .nrst, .processor_reset_n,
    .pc_in, .data_bus_lines_out, .data_bus_lines_oe, .address_bus_lines,
    .rw, .rw_valid, .status_out);
`default_nettype wire

// ==== dv/tb_cpu_reset_interrupt_sequencer.sv ====
// Self-checking bench for the reset and interrupt sequencer.
// Assumes crs_mem_model as the far side.
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_reset_interrupt_sequencer;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, processor_reset_n = 1'b0;
    logic irq_n = 1'b1, insn_done = 1'b0, mask_clr = 1'b0, mask_set = 1'b0;
    logic [15:0] pc_in = 16'h2468, addr, pc_out;
    logic [7:0]  din, dout, st, sp;
    logic        oe, rw, rw_valid, core_run, pc_load;
    int          bad_count = 0, num_checks = 0, n;
    crs_sequencer dut (.clk, .nrst, .ce, .processor_reset_n, .irq_n,
        .insn_done, .mask_clr, .mask_set, .pc_in, .data_bus_lines_in(din),
        .data_bus_lines_out(dout), .data_bus_lines_oe(oe),
        .address_bus_lines(addr), .rw, .rw_valid, .core_run, .pc_out,
        .pc_load, .status_out(st), .sp_out(sp));
    crs_mem_model mem (.addr, .oe, .rdata(din));
    initial forever #20 clk = ~clk;
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %b exp %b", $time, g, e);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    // Bounded waits for a vector fetch, a write or a load
    task automatic wait_on(input int w);
        n = 0;
        #1;
        while (n < 40 && !(w == 0 ? addr === 16'hFFFC :
               w == 1 ? rw === 1'b0 : pc_load === 1'b1)) begin
            tick(1);
            n++;
        end
        if (n == 40) begin
            bad_count++;
            end_sim();
        end
    endtask
    // Count writes over ten cycles
    task automatic quiet();
        n = 0;
        repeat (10) begin
            tick(1);
            if (rw !== 1'b1) n++;
        end
    endtask
    task automatic t_reset();
        tick(8);
        chk_bit(rw_valid, 1'b1);
        chk_bit(oe, 1'b0);
        @(posedge clk);
        processor_reset_n <= 1'b1;
        wait_on(0);
        chk_bit(n inside {[8:12]}, 1'b1);
        wait_on(2);
        chk(pc_out, 16'h1234);
        chk_bit(st[2], 1'b1);
        chk_bit(core_run, 1'b1);
    endtask
    task automatic t_masked();
        @(posedge clk);
        irq_n <= 1'b0;
        tick(6);
        @(posedge clk);
        insn_done <= 1'b1;
        @(posedge clk);
        insn_done <= 1'b0;
        quiet();
        chk(16'(n), 16'h0000);
        @(posedge clk);
        mask_clr <= 1'b1;
        @(posedge clk);
        mask_clr <= 1'b0;
        quiet();
        chk(16'(n), 16'h0000);
    endtask
    task automatic t_take();
        @(posedge clk);
        insn_done <= 1'b1;
        @(posedge clk);
        insn_done <= 1'b0;
        wait_on(1);
        chk(addr, 16'h01FF);
        chk({8'h00, dout}, {8'h00, pc_in[15:8]});
        chk_bit(oe, 1'b1);
        tick(1);
        chk(addr, 16'h01FE);
        chk({8'h00, dout}, {8'h00, pc_in[7:0]});
        tick(1);
        chk(addr, 16'h01FD);
        chk_bit(dout[2], 1'b0);
        wait_on(2);
        chk(pc_out, 16'h5678);
        chk({8'h00, sp}, 16'h00FC);
        chk_bit(st[2], 1'b1);
        irq_n <= 1'b1;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_masked();
        t_take();
        end_sim();
    end
endmodule
`default_nettype wire
